/* hdl/holdoff_regs.svh */
// Register offsets, field positions, reset values and sizes of the strobe holdoff gate
`ifndef HOLDOFF_REGS_SVH
`define HOLDOFF_REGS_SVH

`define HO_ADDR_OUTPUT_SELECT   12'h000
`define HO_ADDR_FIRST_LINE      12'h004
`define HO_ADDR_LINE_COUNT      12'h008
`define HO_ADDR_PULSE_REQUEST   12'h00C
`define HO_ADDR_STATUS          12'h010

`define HO_OUT_LSB              4
`define HO_OUT_MSB              7
`define HO_OUTPUTS              4
`define HO_LINE_BITS            9
`define HO_F0_LSB               0
`define HO_F1_LSB               16
`define HO_SEL_LSB              30
`define HO_SEL_MSB              31
`define HO_ST_ACTIVE            0
`define HO_ST_FIELD             1
`define HO_ST_LINE_LSB          16

`define HO_RESET_OUTPUT_SELECT  4'hF
`define HO_RESET_FIRST_LINE_F0  9'h009
`define HO_RESET_FIRST_LINE_F1  9'h008
`define HO_RESET_LINE_COUNT     9'h001

`endif

/* hdl/holdoff_pkg.sv */
// Types shared by the strobe holdoff gate
package holdoff_pkg;

    typedef enum logic [1:0] {
        field_zero_select  = 2'b00,
        field_one_select   = 2'b01,
        both_fields_select = 2'b10
    } field_sel_t;

    typedef enum logic [1:0] {
        gate_idle    = 2'b00,
        gate_waiting = 2'b01,
        gate_firing  = 2'b10
    } gate_state_t;

endpackage

/* hdl/output_postpone.sv */
// One strobe output: fires a request at once or holds it until the window closes
`timescale 1ns/100ps

module output_postpone (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Control
    input  wire logic request,
    input  wire logic obeys_window,
    input  wire logic window_active,
    // Results
    output logic      fire,
    output logic      pending
);

    holdoff_pkg::gate_state_t state;
    holdoff_pkg::gate_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            holdoff_pkg::gate_idle: begin
                if (request && obeys_window && window_active) begin
                    next_state = holdoff_pkg::gate_waiting;
                end else if (request) begin
                    next_state = holdoff_pkg::gate_firing;
                end
            end
            holdoff_pkg::gate_waiting: begin
                // Mask changes act at once: a cleared bit releases a held request
                if (!(obeys_window && window_active)) begin
                    next_state = holdoff_pkg::gate_firing;
                end
            end
            holdoff_pkg::gate_firing: begin
                if (request && obeys_window && window_active) begin
                    next_state = holdoff_pkg::gate_waiting;
                end else if (!request) begin
                    next_state = holdoff_pkg::gate_idle;
                end
            end
            default: begin
                next_state = holdoff_pkg::gate_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= holdoff_pkg::gate_idle;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign fire    = (state == holdoff_pkg::gate_firing);
    assign pending = (state == holdoff_pkg::gate_waiting);

endmodule // output_postpone

/* hdl/strobe_holdoff_gate.sv */
// Strobe holdoff gate for output lines 4 to 7 with an AHB-Lite register slave
//
// Notes on behaviour
// - A mask bit per output line 4 to 7 makes that output obey the holdoff window when set and exempts it when clear.
// - An immediate or triggered pulse request that meets an active window on a masked output fires when the window ends.
// - After reset all four outputs 4 to 7 are masked into the holdoff.
// - Start and width are held apart for each field, and each write selects field zero, field one or both.
// - The window of a field begins at that field's programmed start line.
// - After reset the start line is 9 for field zero and 8 for field one.
// - The window length is a programmable count of video lines per field, measured from the start line.
// - After reset the width is one line for each field.
// - Mask, start and width writes act at once, never waiting on queued capture work.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "holdoff_regs.svh"

module strobe_holdoff_gate #(
    parameter int OUTPUTS   = `HO_OUTPUTS,
    parameter int LINE_BITS = `HO_LINE_BITS
) (
    // Clock, reset and enable
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // Video timing
    input  wire logic                 field_start,
    input  wire logic                 field_id,
    input  wire logic                 line_start,
    // Trigger-driven requests, one bit per output 4 to 7
    input  wire logic [OUTPUTS-1:0]   triggered_pulse_request,
    // Strobe fire pulses for outputs 4 to 7
    output logic [OUTPUTS-1:0]        strobe_fire
);

    // Register state
    logic [OUTPUTS-1:0]   holdoff_output_select;
    logic [LINE_BITS-1:0] holdoff_first_line [2];
    logic [LINE_BITS-1:0] holdoff_line_count [2];
    logic [OUTPUTS-1:0]   immediate_pulse_request;
    logic [OUTPUTS-1:0]   next_output_select;
    logic [LINE_BITS-1:0] next_first_line [2];
    logic [LINE_BITS-1:0] next_line_count [2];
    logic [OUTPUTS-1:0]   next_immediate;

    // Bus state
    logic                 wr_pending;
    logic [11:0]          wr_addr;
    logic [31:0]          rd_data;
    logic                 next_wr_pending;
    logic [11:0]          next_wr_addr;
    logic [31:0]          next_rd_data;

    // Video timing state
    logic [LINE_BITS-1:0] line_number;
    logic                 current_field;
    logic                 window_active;
    logic [LINE_BITS-1:0] next_line_number;
    logic                 next_current_field;
    logic                 next_window_active;

    // Output state
    logic [OUTPUTS-1:0]   fire_now;
    logic [OUTPUTS-1:0]   pending;
    logic [OUTPUTS-1:0]   fire_q;
    logic                 ready_q;
    logic                 resp_q;

    // True when a write carrying this field selector touches the given field
    function automatic logic field_hit(input logic [1:0] sel, input logic fld);
        field_hit = (sel == holdoff_pkg::both_fields_select) ||
                    (sel == holdoff_pkg::field_zero_select && !fld) ||
                    (sel == holdoff_pkg::field_one_select && fld);
    endfunction

    logic       addr_phase;
    logic [1:0] wr_sel;
    assign addr_phase = hsel && hready && htrans[1];
    assign wr_sel     = hwdata[`HO_SEL_MSB:`HO_SEL_LSB];

    // Bus address phase capture and read data
    always_comb begin
        next_wr_pending = 1'b0;
        next_wr_addr    = wr_addr;
        next_rd_data    = rd_data;
        if (addr_phase) begin
            next_wr_pending = hwrite;
            next_wr_addr    = haddr[11:0];
            next_rd_data    = 32'h0000_0000;
            if (!hwrite) begin
                if (haddr[11:0] == `HO_ADDR_OUTPUT_SELECT) begin
                    next_rd_data[`HO_OUT_MSB:`HO_OUT_LSB] = holdoff_output_select;
                end else if (haddr[11:0] == `HO_ADDR_FIRST_LINE) begin
                    next_rd_data[`HO_F0_LSB +: LINE_BITS] = holdoff_first_line[0];
                    next_rd_data[`HO_F1_LSB +: LINE_BITS] = holdoff_first_line[1];
                end else if (haddr[11:0] == `HO_ADDR_LINE_COUNT) begin
                    next_rd_data[`HO_F0_LSB +: LINE_BITS] = holdoff_line_count[0];
                    next_rd_data[`HO_F1_LSB +: LINE_BITS] = holdoff_line_count[1];
                end else if (haddr[11:0] == `HO_ADDR_STATUS) begin
                    next_rd_data[`HO_ST_ACTIVE]                 = window_active;
                    next_rd_data[`HO_ST_FIELD]                  = current_field;
                    next_rd_data[`HO_OUT_MSB:`HO_OUT_LSB]       = pending;
                    next_rd_data[`HO_ST_LINE_LSB +: LINE_BITS] = line_number;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pending <= 1'b0;
            wr_addr    <= 12'h000;
            rd_data    <= 32'h0000_0000;
        end else if (ce) begin
            wr_pending <= next_wr_pending;
            wr_addr    <= next_wr_addr;
            rd_data    <= next_rd_data;
        end
    end

    // Register writes in the data phase, applied at once
    always_comb begin
        next_output_select = holdoff_output_select;
        next_first_line    = holdoff_first_line;
        next_line_count    = holdoff_line_count;
        next_immediate     = '0;
        if (wr_pending) begin
            if (wr_addr == `HO_ADDR_OUTPUT_SELECT) begin
                next_output_select = hwdata[`HO_OUT_MSB:`HO_OUT_LSB];
            end else if (wr_addr == `HO_ADDR_FIRST_LINE) begin
                for (int f = 0; f < 2; f++) begin
                    if (field_hit(wr_sel, f[0])) begin
                        next_first_line[f] = hwdata[LINE_BITS-1:0];
                    end
                end
            end else if (wr_addr == `HO_ADDR_LINE_COUNT) begin
                for (int f = 0; f < 2; f++) begin
                    if (field_hit(wr_sel, f[0])) begin
                        next_line_count[f] = hwdata[LINE_BITS-1:0];
                    end
                end
            end else if (wr_addr == `HO_ADDR_PULSE_REQUEST) begin
                next_immediate = hwdata[`HO_OUT_MSB:`HO_OUT_LSB];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            holdoff_output_select   <= `HO_RESET_OUTPUT_SELECT;
            holdoff_first_line[0]   <= `HO_RESET_FIRST_LINE_F0;
            holdoff_first_line[1]   <= `HO_RESET_FIRST_LINE_F1;
            holdoff_line_count[0]   <= `HO_RESET_LINE_COUNT;
            holdoff_line_count[1]   <= `HO_RESET_LINE_COUNT;
            immediate_pulse_request <= '0;
        end else if (ce) begin
            holdoff_output_select   <= next_output_select;
            holdoff_first_line      <= next_first_line;
            holdoff_line_count      <= next_line_count;
            immediate_pulse_request <= next_immediate;
        end
    end

    // Line counting within the field and window decision
    logic [LINE_BITS:0] win_end;
    logic               sel_f;
    always_comb begin
        next_line_number   = line_number;
        next_current_field = current_field;
        if (field_start) begin
            next_line_number   = {{(LINE_BITS-1){1'b0}}, 1'b1};
            next_current_field = field_id;
        end else if (line_start && line_number != {LINE_BITS{1'b1}}) begin
            next_line_number = line_number + 1'b1;
        end
        sel_f   = next_current_field;
        win_end = {1'b0, holdoff_first_line[sel_f]} + {1'b0, holdoff_line_count[sel_f]};
        next_window_active = (next_line_number >= holdoff_first_line[sel_f]) &&
                             ({1'b0, next_line_number} < win_end);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_number   <= '0;
            current_field <= 1'b0;
            window_active <= 1'b0;
        end else if (ce) begin
            line_number   <= next_line_number;
            current_field <= next_current_field;
            window_active <= next_window_active;
        end
    end

    // One postponing gate per output line
    generate
        for (genvar i = 0; i < OUTPUTS; i++) begin : g_out
            output_postpone u_gate (
                .clk           (clk),
                .resetn        (resetn),
                .ce            (ce),
                .request       (immediate_pulse_request[i] | triggered_pulse_request[i]),
                .obeys_window  (holdoff_output_select[i]),
                .window_active (window_active),
                .fire          (fire_now[i]),
                .pending       (pending[i])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fire_q <= '0;
        end else if (ce) begin
            fire_q <= fire_now;
        end
    end

    // Zero wait states and an OKAY response, both held in flip-flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
        end else if (ce) begin
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
        end
    end

    assign strobe_fire = fire_q;
    assign hrdata      = rd_data;
    assign hreadyout   = ready_q;
    assign hresp       = resp_q;

endmodule // strobe_holdoff_gate

/* testbench/strobe_holdoff_gate_sva.sv */
// Port assertions for the strobe holdoff gate
`timescale 1ns/100ps
module strobe_holdoff_gate_sva #(parameter int OUTPUTS = 4) (
    // Clock and reset
    input wire logic clk, resetn, ce,
    // Bus
    input wire logic hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr, hwdata, hrdata,
    // Strobes
    input wire logic [OUTPUTS-1:0] triggered_pulse_request, strobe_fire
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic wr_mask;
    logic [3:0] mask_shadow;
    // Shadow of the output mask, written at the end of the data phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_mask <= 1'b0;
            mask_shadow <= 4'hF;
        end else begin
            wr_mask <= ce && hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h000;
            if (wr_mask) mask_shadow <= hwdata[7:4];
        end
    end
    sequence taken; ce && hsel && hready && htrans[1]; endsequence
    sequence rd_at(logic [11:0] a); taken ##0 (!hwrite && haddr[11:0] == a); endsequence
    sequence rd_far; taken ##0 (!hwrite && haddr[11:0] > 12'h010); endsequence
    chk_ready_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    chk_unmapped_zero: assert property (rd_far |=> hrdata == 32'h0) else $error("unmapped read not zero");
    chk_request_reads_zero: assert property (rd_at(12'h00C) |=> hrdata == 32'h0) else $error("request reg read");
    chk_rdata_stands: assert property (!(ce && hsel && hready && htrans[1]) |=> $stable(hrdata))
        else $error("read data moved");
    chk_mask_readback: assert property (rd_at(12'h000) |=> hrdata[7:4] == $past(mask_shadow))
        else $error("mask readback wrong");
    chk_exempt_fire: assert property (ce && $rose(triggered_pulse_request[1]) && !mask_shadow[1]
        |-> ##[2:3] strobe_fire[1]) else $error("exempt output not fired");
    chk_fire_single: assert property ($rose(strobe_fire[0]) && !$past(triggered_pulse_request[0])
        |=> !strobe_fire[0]) else $error("fire pulse too long");
    chk_reset_quiet: assert property ($rose(resetn) |-> strobe_fire == '0 && hrdata == 32'h0)
        else $error("outputs busy after reset");
endmodule // strobe_holdoff_gate_sva

bind strobe_holdoff_gate strobe_holdoff_gate_sva #(.OUTPUTS(OUTPUTS)) u_strobe_holdoff_gate_sva (.clk, .resetn,
    .ce, .hsel, .hwrite, .hready, .hreadyout, .hresp, .htrans, .haddr, .hwdata, .hrdata,
    .triggered_pulse_request, .strobe_fire);

/* testbench/strobe_lamps.sv */
// Lamps on outputs 4 to 7: count every cycle a strobe is fired
`timescale 1ns/100ps
module strobe_lamps (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Strobes in, flash counts out
    input wire logic [3:0] strobe_fire,
    output logic [31:0] lit [4]
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) lit <= '{default: 32'h0};
        else for (int i = 0; i < 4; i++) if (strobe_fire[i]) lit[i] <= lit[i] + 32'h1;
    end
endmodule // strobe_lamps

/* testbench/strobe_holdoff_gate_tb.sv */
// Self-checking bench for the strobe holdoff gate
`timescale 1ns/100ps
`include "holdoff_regs.svh"
module strobe_holdoff_gate_tb;
    logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, field_start = 0, field_id = 0, line_start = 0;
    logic hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [3:0] trig = 4'h0, strobe_fire;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [31:0] lit [4];
    logic [8:0] val [6] = '{9'h005, 9'h007, 9'h003, 9'h004, 9'h006, 9'h002};
    logic [31:0] expv [6] = '{32'h00080005, 32'h00070005, 32'h00030003, 32'h00010004, 32'h00060004, 32'h00020002};
    int num_errors = 0, comparisons = 0;
    always #25 clk = ~clk;
    strobe_holdoff_gate u_strobe_holdoff_gate (.clk, .resetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .field_start, .field_id,
        .line_start, .triggered_pulse_request(trig), .strobe_fire);
    strobe_lamps u_strobe_lamps (.clk, .resetn, .strobe_fire, .lit);

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single transfer: address phase, then data phase
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {20'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd & m, exp);
    endtask
    // Field start or a plain line start
    task vid(input logic fs, input logic id);
        @(posedge clk); field_start <= fs; field_id <= id; line_start <= !fs;
        @(posedge clk); field_start <= 1'b0; line_start <= 1'b0;
    endtask
    task pulse(input logic [3:0] b);
        @(posedge clk); trig <= b;
        @(posedge clk); trig <= 4'h0;
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rd_chk("mask", `HO_ADDR_OUTPUT_SELECT, 32'hF0, 32'hF0);
        rd_chk("first line", `HO_ADDR_FIRST_LINE, 32'h01FF01FF, 32'h00080009);
        rd_chk("line count", `HO_ADDR_LINE_COUNT, 32'h01FF01FF, 32'h00010001);
        rd_chk("unmapped", 12'h020, 32'hFFFFFFFF, 32'h0);
        rd_chk("request reg", `HO_ADDR_PULSE_REQUEST, 32'hFFFFFFFF, 32'h0);
        $display("test defaults done");
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, i < 3 ? `HO_ADDR_FIRST_LINE : `HO_ADDR_LINE_COUNT, {2'(i % 3), 21'h0, val[i]});
            rd_chk("field setting", i < 3 ? `HO_ADDR_FIRST_LINE : `HO_ADDR_LINE_COUNT, 32'h01FF01FF, expv[i]);
        end
        $display("test field settings done");
        vid(1'b1, 1'b0);
        vid(1'b0, 1'b0);
        rd_chk("line two", `HO_ADDR_STATUS, 32'h01FF0001, 32'h00020000);
        vid(1'b0, 1'b0);
        rd_chk("line three", `HO_ADDR_STATUS, 32'h1, 32'h1);
        pulse(4'h1);
        bus(1'b1, `HO_ADDR_PULSE_REQUEST, 32'h20);
        repeat (6) @(posedge clk);
        check("held out4", lit[0], 32'h0);
        check("held out5", lit[1], 32'h0);
        bus(1'b1, `HO_ADDR_OUTPUT_SELECT, 32'hD0);
        repeat (4) @(posedge clk);
        check("released out5", lit[1], 32'h1);
        vid(1'b0, 1'b0);
        rd_chk("line four", `HO_ADDR_STATUS, 32'h1, 32'h1);
        check("still held out4", lit[0], 32'h0);
        vid(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        check("fired out4", lit[0], 32'h1);
        rd_chk("line five", `HO_ADDR_STATUS, 32'h1, 32'h0);
        $display("test postpone done");
        vid(1'b1, 1'b0);
        vid(1'b0, 1'b0);
        vid(1'b0, 1'b0);
        pulse(4'h2);
        repeat (4) @(posedge clk);
        check("exempt out5", lit[1], 32'h2);
        $display("test exempt done");
        bus(1'b1, `HO_ADDR_FIRST_LINE, 32'h40000006);
        bus(1'b1, `HO_ADDR_LINE_COUNT, 32'h40000001);
        vid(1'b1, 1'b1);
        repeat (5) vid(1'b0, 1'b1);
        rd_chk("field one line six", `HO_ADDR_STATUS, 32'h01FF0003, 32'h00060003);
        vid(1'b0, 1'b1);
        rd_chk("field one line seven", `HO_ADDR_STATUS, 32'h1, 32'h0);
        $display("test field one done");
        print_verdict;
    end
endmodule // strobe_holdoff_gate_tb
